/* File: design/zcd_edge.sv */
// Synchroniser, polarity stage and edge detectors of the detector output
`timescale 1ns/10ps
`include "zcd_regs.svh"
module zcd_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_above_ref,
   input wire logic active,
   input wire logic invert,
   zcd_edge_if.src ev
);
   logic s1_q, s1_d;
   logic s2_q, s2_d;
   logic lvl_q, lvl_d;
   logic prev_q, prev_d;
   // ==========================================================
   // Two flops before any logic; stage one is read by stage two only
   always_comb begin
      s1_d = pin_above_ref;
      s2_d = s1_q;
      lvl_d = (active & s2_q) ^ invert;
      prev_d = lvl_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= `RST_BIT;
         s2_q <= `RST_BIT;
         lvl_q <= `RST_BIT;
         prev_q <= `RST_BIT;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         lvl_q <= lvl_d;
         prev_q <= prev_d;
      end
   end
   // ==========================================================
   // Edges are taken after the inversion, so polarity picks the crossing
   assign ev.dec = s2_q;
   assign ev.level = lvl_q;
   assign ev.rise = lvl_q & ~prev_q;
   assign ev.fall = ~lvl_q & prev_q;
   property p_sync_two;
      @(posedge pclk) disable iff (!presetn)
      ##2 (s2_q == $past(pin_above_ref, 2));
   endproperty
   a_sync_two: assert property (p_sync_two) else $error("decision not two flops late");
endmodule

/* File: design/zcd_edge_if.sv */
// Carrier for the synchronised decision, logic output and edge pulses
`timescale 1ns/10ps
interface zcd_edge_if;
   logic dec;
   logic level;
   logic rise;
   logic fall;
   modport src (output dec, output level, output rise, output fall);
   modport dst (input dec, input level, input rise, input fall);
endinterface

/* File: design/zcd_irq.sv */
// Crossing flag with edge qualification and interrupt gating
`timescale 1ns/10ps
`include "zcd_regs.svh"
module zcd_irq (
   input wire logic pclk,
   input wire logic presetn,
   zcd_edge_if.dst ev,
   input wire logic rise_edge_enable,
   input wire logic fall_edge_enable,
   input wire logic flag_clear,
   input wire logic crossing_irq_enable,
   input wire logic global_irq_enable,
   input wire logic peripheral_group_irq_enable,
   output logic crossing_irq_flag,
   output logic irq
);
   logic flag_q, flag_d;
   logic set;
   // ==========================================================
   // Set beats a clear in the same cycle, so no edge is lost
   always_comb begin
      set = (ev.rise & rise_edge_enable) | (ev.fall & fall_edge_enable);
      flag_d = set | (flag_q & ~flag_clear);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= `RST_BIT;
      end else begin
         flag_q <= flag_d;
      end
   end
   assign crossing_irq_flag = flag_q;
   assign irq = flag_q & crossing_irq_enable & global_irq_enable
      & peripheral_group_irq_enable;
   property p_rise_sets;
      @(posedge pclk) disable iff (!presetn)
      (ev.rise && rise_edge_enable) |=> flag_q;
   endproperty
   a_rise_sets: assert property (p_rise_sets) else $error("rise edge lost");
   property p_unqual_quiet;
      @(posedge pclk) disable iff (!presetn)
      (!flag_q && !(ev.rise && rise_edge_enable) && !(ev.fall && fall_edge_enable))
         |=> !flag_q;
   endproperty
   a_unqual_quiet: assert property (p_unqual_quiet) else $error("flag set unqualified");
   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      (set && flag_clear) |=> flag_q;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat set");
endmodule

/* File: design/zcd_pkg.sv */
// Types shared by the zero-cross detector modules
package zcd_pkg;
   typedef enum logic [1:0] {
      ST_CAPTURE = 2'b01,
      ST_RUN = 2'b10
   } cap_state_t;
   typedef struct packed {
      logic en;
      logic invert;
      logic rise;
      logic fall;
   } ctrl_t;
endpackage

/* File: design/zcd_regs.svh */
// Register offsets, bit positions and counts of the zero-cross detector
`ifndef ZCD_REGS_SVH
`define ZCD_REGS_SVH
// ==========================================================
// Register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_FLAG 12'h004
`define ADDR_IEN 12'h008
`define ADDR_CORE 12'h00c
// ==========================================================
// Field positions
`define CTRL_EN 7
`define CTRL_OUT 5
`define CTRL_INV 4
`define CTRL_RISE 1
`define CTRL_FALL 0
`define FLAG_BIT 0
`define IEN_BIT 0
`define CORE_GLOBAL 7
`define CORE_GROUP 6
// ==========================================================
// Reset values and counts
`define RST_BIT 1'h0
`define RST_WORD 32'h0000_0000
`define CAP_WAIT 2'h2
`define CNT_ONE 2'h1
`endif

/* File: design/zcd_top.sv */
// Zero-cross detector digital side with APB registers
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "zcd_regs.svh"
module zcd_top
   import zcd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pin_above_ref,
   input wire logic detector_cfg_bit,
   output logic sink_on,
   output logic source_on,
   output logic irq
);
   // ==========================================================
   // Declarations
   ctrl_t ctrl_q, ctrl_d;
   logic ien_q, ien_d;
   logic glob_q, glob_d;
   logic grp_q, grp_d;
   logic [31:0] rd_q, rd_d;
   logic cfg_s1_q, cfg_s1_d;
   logic cfg_s2_q, cfg_s2_d;
   logic cfg_q, cfg_d;
   logic [1:0] cnt_q, cnt_d;
   cap_state_t st_q, st_d;
   logic sink_q, sink_d;
   logic src_q, src_d;
   logic rst_seen_q;
   logic active;
   logic hit;
   logic setup_rd;
   logic wr;
   logic flag_clear;
   logic flag;
   zcd_edge_if ev ();

   // ==========================================================
   // Configuration bit capture after reset release
   always_comb begin
      cfg_s1_d = detector_cfg_bit;
      cfg_s2_d = cfg_s1_q;
      cfg_d = cfg_q;
      cnt_d = cnt_q;
      st_d = st_q;
      case (st_q)
         ST_CAPTURE: begin
            cnt_d = cnt_q + `CNT_ONE;
            if (cnt_q == `CAP_WAIT) begin
               cfg_d = cfg_s2_q;
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            cnt_d = cnt_q;
         end
         default: begin
            st_d = ST_CAPTURE;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_s1_q <= `RST_BIT;
         cfg_s2_q <= `RST_BIT;
         cfg_q <= `RST_BIT;
         cnt_q <= '0;
         st_q <= ST_CAPTURE;
      end else begin
         cfg_s1_q <= cfg_s1_d;
         cfg_s2_q <= cfg_s2_d;
         cfg_q <= cfg_d;
         cnt_q <= cnt_d;
         st_q <= st_d;
      end
   end
   // Enable is ignored when the configuration bit reads clear
   assign active = (st_q == ST_RUN) && (!cfg_q || ctrl_q.en);

   // ==========================================================
   // APB decode; zero wait states
   assign hit = (paddr == `ADDR_CTRL) || (paddr == `ADDR_FLAG)
      || (paddr == `ADDR_IEN) || (paddr == `ADDR_CORE);
   assign setup_rd = psel && !penable && !pwrite;
   assign wr = psel && penable && pwrite && hit;
   assign flag_clear = wr && (paddr == `ADDR_FLAG) && pwdata[`FLAG_BIT];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;

   // ==========================================================
   // Register writes
   always_comb begin
      ctrl_d = ctrl_q;
      ien_d = ien_q;
      glob_d = glob_q;
      grp_d = grp_q;
      if (wr && paddr == `ADDR_CTRL) begin
         ctrl_d.en = pwdata[`CTRL_EN];
         ctrl_d.invert = pwdata[`CTRL_INV];
         ctrl_d.rise = pwdata[`CTRL_RISE];
         ctrl_d.fall = pwdata[`CTRL_FALL];
      end
      if (wr && paddr == `ADDR_IEN) begin
         ien_d = pwdata[`IEN_BIT];
      end
      if (wr && paddr == `ADDR_CORE) begin
         glob_d = pwdata[`CORE_GLOBAL];
         grp_d = pwdata[`CORE_GROUP];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         ien_q <= `RST_BIT;
         glob_q <= `RST_BIT;
         grp_q <= `RST_BIT;
      end else begin
         ctrl_q <= ctrl_d;
         ien_q <= ien_d;
         glob_q <= glob_d;
         grp_q <= grp_d;
      end
   end

   // ==========================================================
   // Read data is caught in the setup cycle, one cycle old at access
   always_comb begin
      rd_d = rd_q;
      if (setup_rd) begin
         rd_d = `RST_WORD;
         case (paddr)
            `ADDR_CTRL: begin
               rd_d[`CTRL_EN] = ctrl_q.en;
               rd_d[`CTRL_OUT] = ev.level;
               rd_d[`CTRL_INV] = ctrl_q.invert;
               rd_d[`CTRL_RISE] = ctrl_q.rise;
               rd_d[`CTRL_FALL] = ctrl_q.fall;
            end
            `ADDR_FLAG: begin
               rd_d[`FLAG_BIT] = flag;
            end
            `ADDR_IEN: begin
               rd_d[`IEN_BIT] = ien_q;
            end
            `ADDR_CORE: begin
               rd_d[`CORE_GLOBAL] = glob_q;
               rd_d[`CORE_GROUP] = grp_q;
            end
            default: begin
               rd_d = `RST_WORD;
            end
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= `RST_WORD;
      end else begin
         rd_q <= rd_d;
      end
   end
   assign prdata = rd_q;

   // ==========================================================
   // Current sink and source select
   always_comb begin
      sink_d = active & ev.dec;
      src_d = active & ~ev.dec;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sink_q <= `RST_BIT;
         src_q <= `RST_BIT;
         rst_seen_q <= `RST_BIT;
      end else begin
         sink_q <= sink_d;
         src_q <= src_d;
         rst_seen_q <= 1'b1;
      end
   end
   assign sink_on = sink_q;
   assign source_on = src_q;

   // ==========================================================
   // Detector datapath and flag
   zcd_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin_above_ref(pin_above_ref),
      .active(active),
      .invert(ctrl_q.invert),
      .ev(ev.src)
   );
   zcd_irq u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .ev(ev.dst),
      .rise_edge_enable(ctrl_q.rise),
      .fall_edge_enable(ctrl_q.fall),
      .flag_clear(flag_clear),
      .crossing_irq_enable(ien_q),
      .global_irq_enable(glob_q),
      .peripheral_group_irq_enable(grp_q),
      .crossing_irq_flag(flag),
      .irq(irq)
   );

   // ==========================================================
   // Checks
   property p_sink_sel;
      @(posedge pclk) disable iff (!presetn)
      (active && ev.dec) |=> (sink_on && !source_on);
   endproperty
   a_sink_sel: assert property (p_sink_sel) else $error("sink not selected");
   property p_out_plain;
      @(posedge pclk) disable iff (!presetn)
      (!ctrl_q.invert && active && ev.dec) |=> ev.level;
   endproperty
   a_out_plain: assert property (p_out_plain) else $error("output not high on sink");
   property p_out_inv;
      @(posedge pclk) disable iff (!presetn)
      (ctrl_q.invert && active && ev.dec) |=> !ev.level;
   endproperty
   a_out_inv: assert property (p_out_inv) else $error("inverted output wrong");
   sequence s_inv_flip;
      $changed(ctrl_q.invert) && $stable(ev.dec) && $stable(active);
   endsequence
   // Only the edge that the flip makes counts, so its own enable must be set
   sequence s_edge_armed;
      (ctrl_q.rise && !ev.level) || (ctrl_q.fall && ev.level);
   endsequence
   property p_inv_edge;
      @(posedge pclk) disable iff (!presetn)
      (s_inv_flip ##0 s_edge_armed) |=> (ev.rise || ev.fall) ##1 flag;
   endproperty
   a_inv_edge: assert property (p_inv_edge) else $error("no flag on flip");
   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn)
      irq |-> (flag && ien_q && glob_q && grp_q);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");
   property p_always_on;
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_RUN && !cfg_q && !ctrl_q.en) |=> (sink_on || source_on);
   endproperty
   a_always_on: assert property (p_always_on) else $error("detector off with cfg clear");
   property p_ctrl_reset;
      @(posedge pclk) disable iff (!presetn)
      !rst_seen_q |-> (ctrl_q == '0);
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not reset");
   property p_capture_time;
      @(posedge pclk) disable iff (!presetn)
      $rose(rst_seen_q) |-> ##[1:3] (st_q == ST_RUN);
   endproperty
   a_capture_time: assert property (p_capture_time) else $error("configuration not captured");
   property p_source_sel;
      @(posedge pclk) disable iff (!presetn)
      (active && !ev.dec) |=> (source_on && !sink_on);
   endproperty
   a_source_sel: assert property (p_source_sel) else $error("source not selected");
   // Both current paths off while inactive, so the pin is left to the port
   property p_idle_off;
      @(posedge pclk) disable iff (!presetn)
      !active |=> (!sink_on && !source_on);
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("current driven while off");
   property p_fall_sets;
      @(posedge pclk) disable iff (!presetn)
      (ev.fall && ctrl_q.fall) |=> flag;
   endproperty
   a_fall_sets: assert property (p_fall_sets) else $error("fall edge lost");
   property p_flag_holds;
      @(posedge pclk) disable iff (!presetn)
      (flag && !flag_clear) |=> flag;
   endproperty
   a_flag_holds: assert property (p_flag_holds) else $error("flag dropped early");
   property p_clear_works;
      @(posedge pclk) disable iff (!presetn)
      (flag_clear && !(ev.rise && ctrl_q.rise) && !(ev.fall && ctrl_q.fall)) |=> !flag;
   endproperty
   a_clear_works: assert property (p_clear_works) else $error("flag not cleared");
   property p_irq_full;
      @(posedge pclk) disable iff (!presetn)
      (flag && ien_q && glob_q && grp_q) |-> irq;
   endproperty
   a_irq_full: assert property (p_irq_full) else $error("irq missing");
endmodule

/* File: testbench/ac_source_model.sv */
// Behavioural AC source seen through the series resistor
`timescale 1ns/10ps
module ac_source_model (
   input wire logic pclk,
   input wire logic level_cmd,
   input wire logic slow,
   output logic pin_above_ref
);
   // ==========================================================
   // Source
   // Slow mode mimics a lagging RC front end
   logic [2:0] lag_q = 3'h0;
   always @(posedge pclk) begin
      lag_q <= {lag_q[1:0], level_cmd};
   end
   assign pin_above_ref = slow ? lag_q[2] : level_cmd;
endmodule

/* File: testbench/zero_cross_detect_logic_tb.sv */
// Self-checking bench of the zero-cross detector
`timescale 1ns/10ps
`include "zcd_regs.svh"
module zero_cross_detect_logic_tb;
   logic pclk, presetn, psel, penable, pwrite, lvl, slow, cfg, pready, pslverr;
   logic pin, sink_on, source_on, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int failures = 0;
   int samples_checked = 0;

   ac_source_model far (.pclk(pclk), .level_cmd(lvl), .slow(slow), .pin_above_ref(pin));
   zcd_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_above_ref(pin), .detector_cfg_bit(cfg), .sink_on(sink_on),
      .source_on(source_on), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ==========================================================
   // Checks and verdict
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Bus access
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         tally_and_finish();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rreg(input logic [11:0] a, input string nm, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask

   // Sample 1 ns after the edge so register updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   initial begin
      #200000;
      failures++;
      tally_and_finish();
   end

   // ==========================================================
   // Scenarios
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lvl = 1'b0;
      slow = 1'b0;
      cfg = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rreg(`ADDR_CTRL, "ctrl", 32'h0);
      rreg(`ADDR_FLAG, "flag", 32'h0);
      rreg(`ADDR_IEN, "ien", 32'h0);
      rreg(`ADDR_CORE, "core", 32'h0);
      rreg(12'h010, "unmapped", 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      lvl <= 1'b1;
      cyc(6);
      chk("sink idle", 32'h0, {31'h0, sink_on});
      chk("source idle", 32'h0, {31'h0, source_on});
      wreg(`ADDR_CTRL, 32'h83);
      cyc(5);
      chk("sink", 32'h1, {31'h0, sink_on});
      rreg(`ADDR_CTRL, "ctrl out", 32'ha3);
      wreg(`ADDR_FLAG, 32'h1);
      rreg(`ADDR_FLAG, "flag clr", 32'h0);
      @(posedge pclk);
      lvl <= 1'b0;
      cyc(2);
      chk("sink sync", 32'h1, {31'h0, sink_on});
      cyc(1);
      chk("source", 32'h1, {31'h0, source_on});
      rreg(`ADDR_FLAG, "flag fall", 32'h1);
      wreg(`ADDR_FLAG, 32'h1);
      // Inverted output, rise edges only
      wreg(`ADDR_CTRL, 32'h92);
      cyc(3);
      rreg(`ADDR_FLAG, "flag invert", 32'h1);
      rreg(`ADDR_CTRL, "ctrl inv", 32'hb2);
      wreg(`ADDR_FLAG, 32'h1);
      lvl <= 1'b1;
      cyc(6);
      rreg(`ADDR_FLAG, "flag inv fall", 32'h0);
      lvl <= 1'b0;
      cyc(6);
      rreg(`ADDR_FLAG, "flag inv rise", 32'h1);
      // Polarity write while disabled
      wreg(`ADDR_CTRL, 32'h02);
      cyc(4);
      wreg(`ADDR_FLAG, 32'h1);
      rreg(`ADDR_FLAG, "flag off", 32'h0);
      wreg(`ADDR_CTRL, 32'h12);
      cyc(3);
      rreg(`ADDR_FLAG, "flag invert off", 32'h1);
      chk("sink off", 32'h0, {31'h0, sink_on});
      for (int i = 0; i < 8; i++) begin
         wreg(`ADDR_IEN, {31'h0, i[0]});
         wreg(`ADDR_CORE, {24'h0, i[2], i[1], 6'h0});
         cyc(2);
         chk("irq gate", {31'h0, i == 7}, {31'h0, irq});
      end
      wreg(`ADDR_FLAG, 32'h1);
      cyc(2);
      chk("irq clr", 32'h0, {31'h0, irq});
      // Edge lands on the clearing write
      wreg(`ADDR_CTRL, 32'h83);
      cyc(6);
      wreg(`ADDR_FLAG, 32'h1);
      cyc(1);
      @(posedge pclk);
      lvl <= 1'b1;
      @(posedge pclk);
      wreg(`ADDR_FLAG, 32'h1);
      cyc(2);
      rreg(`ADDR_FLAG, "flag race", 32'h1);
      chk("irq race", 32'h1, {31'h0, irq});
      slow <= 1'b1;
      lvl <= 1'b0;
      cyc(9);
      chk("source slow", 32'h1, {31'h0, source_on});
      // Strap cleared: active without the enable bit
      @(posedge pclk);
      presetn <= 1'b0;
      cfg <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      cyc(8);
      chk("source strap", 32'h1, {31'h0, source_on});
      rreg(`ADDR_CTRL, "ctrl strap", 32'h0);
      lvl <= 1'b1;
      cyc(8);
      chk("sink strap", 32'h1, {31'h0, sink_on});
      tally_and_finish();
   end
endmodule
